// File: logic/dtm_timer_top.sv
// Dual timer with mode, gate and clock-source selection behind SFR access
//
// Behaviour
// - Timer 1 gate clear: run whenever its run bit is set, ignore irq 1.
// - Timer 1 gate set: run only with run bit set and irq 1 active.
// - Reserved mode bits read zero; software writes zero there.
// - Timer 1 mode: 13-bit, 16-bit, 8-bit reload, or inactive.
// - Timer 0 gate clear: run whenever its run bit is set, ignore irq 0.
// - Timer 0 gate set: run only with run bit set and irq 0 active.
// - Timer 0 mode: 13-bit, 16-bit, 8-bit reload, or two 8-bit timers.
// - Timer 1 clock select: zero prescaled clock, one system clock.
// - Timer 0 clock select: zero prescaled clock, one system clock.
// - Prescale code divides system clock by 12, 4 or 48.
// - Fourth prescale code uses external clock divided by 8, synchronised.
// - Upper four clock-select bits read zero, writes ignored.
// - Timer 0 count is two byte-wide read/write registers.
// - Timer 1 count is two byte-wide read/write registers, reset zero.
// - 13-bit wrap from all ones sets that timer's overflow flag, except timer 1 with timer 0 split.
// - Reload mode: low overflow sets flag (not timer 1's with timer 0 split), reloads low from unchanged high.
// - Split mode: timer 0 high byte runs by timer 1 run bit, sets timer 1 flag.
// - Overflow flags set by hardware, cleared by software or vectoring.
module dtm_timer_top
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Special-function register access
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_en_in,
  input wire logic [7:0] sfr_wr_data_in,
  input wire logic sfr_rd_en_in,
  output logic [7:0] sfr_rd_data_out,
  // Pins, active-low external interrupts and external clock
  input wire logic ext_irq0_n_in,
  input wire logic ext_irq1_n_in,
  input wire logic ext_clk_in,
  // Interrupt vector acknowledges from the processor
  input wire logic tmr0_vector_ack_in,
  input wire logic tmr1_vector_ack_in,
  // Overflow flags and timer 1 overflow pulse
  output logic timer0_overflow_flag_out,
  output logic timer1_overflow_flag_out,
  output logic timer1_ovf_pulse_out
);

  // Register map, field positions and types
  import dtm_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Advance one count by one step in the given mode
  function automatic dtm_step_s step_timer(input dtm_count_s c, input dtm_mode_e mode);
    dtm_step_s r;
    logic [12:0] v13;
    logic [15:0] v16;
    r = '{cnt: c, ovf: 1'b0};
    v13 = 13'h0000;
    v16 = 16'h0000;
    case (mode)
      DTM_MODE_13BIT: begin
        // Upper three low-byte bits keep their value; software masks them
        v13 = {c.hi, c.lo[4:0]} + 13'h0001;
        r.cnt.hi = v13[12:5];
        r.cnt.lo = {c.lo[7:5], v13[4:0]};
        r.ovf = ({c.hi, c.lo[4:0]} == 13'h1FFF);
      end
      DTM_MODE_16BIT: begin
        v16 = {c.hi, c.lo} + 16'h0001;
        r.cnt = v16;
        r.ovf = ({c.hi, c.lo} == 16'hFFFF);
      end
      DTM_MODE_RELOAD8: begin
        // High byte holds the reload value and never counts here
        r.ovf = (c.lo == 8'hFF);
        r.cnt.lo = r.ovf ? c.hi : c.lo + 8'h01;
      end
      default: begin
        // Split: low byte alone as an 8-bit counter
        r.cnt.lo = c.lo + 8'h01;
        r.ovf = (c.lo == 8'hFF);
      end
    endcase
    return r;
  endfunction

  // Pin level update: follow only when the last two stages agree
  function automatic logic settle(input logic [2:0] s, input logic cur);
    return (s[1] == s[2]) ? s[2] : cur;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [2:0] irq0_sync_q, irq0_sync_d;
  logic [2:0] irq1_sync_q, irq1_sync_d;
  logic [2:0] eclk_sync_q, eclk_sync_d;
  logic irq0_lvl_q, irq0_lvl_d;
  logic irq1_lvl_q, irq1_lvl_d;
  logic eclk_lvl_q, eclk_lvl_d;

  // Three-stage shift; stage 0 feeds only stage 1
  // Costs a few cycles of pin latency, but a metastable stage 0 stays private
  always_comb begin
    irq0_sync_d = {irq0_sync_q[1:0], ext_irq0_n_in};
    irq1_sync_d = {irq1_sync_q[1:0], ext_irq1_n_in};
    eclk_sync_d = {eclk_sync_q[1:0], ext_clk_in};
    irq0_lvl_d = settle(irq0_sync_q, irq0_lvl_q);
    irq1_lvl_d = settle(irq1_sync_q, irq1_lvl_q);
    eclk_lvl_d = settle(eclk_sync_q, eclk_lvl_q);
  end

  // Idle interrupt pins high (inactive) after reset; external clock low
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      irq0_sync_q <= 3'h7;
      irq1_sync_q <= 3'h7;
      eclk_sync_q <= 3'h0;
      irq0_lvl_q <= 1'b1;
      irq1_lvl_q <= 1'b1;
      eclk_lvl_q <= 1'b0;
    end else begin
      irq0_sync_q <= irq0_sync_d;
      irq1_sync_q <= irq1_sync_d;
      eclk_sync_q <= eclk_sync_d;
      irq0_lvl_q <= irq0_lvl_d;
      irq1_lvl_q <= irq1_lvl_d;
      eclk_lvl_q <= eclk_lvl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers and timers

  logic [7:0] mode_sel_q, mode_sel_d;
  logic [7:0] clk_sel_q, clk_sel_d;
  logic t0_run_q, t0_run_d;
  logic t1_run_q, t1_run_d;
  logic t0_flag_q, t0_flag_d;
  logic t1_flag_q, t1_flag_d;
  dtm_count_s t0_q, t0_d;
  dtm_count_s t1_q, t1_d;
  logic [5:0] pre_cnt_q, pre_cnt_d;
  logic [2:0] ext_cnt_q, ext_cnt_d;
  logic eclk_prev_q, eclk_prev_d;
  logic [7:0] rd_data_q, rd_data_d;
  logic t1_pulse_q, t1_pulse_d;

  // Decoded controls
  dtm_mode_e mode0, mode1;
  logic [1:0] scale;
  logic [5:0] div_last;
  logic pre_tick, tick0, tick1, run0, run1;
  logic hi0_run, set_flag0, set_flag1, clr_flag0, clr_flag1;
  logic wr_run, wr_mode, wr_clk;
  dtm_step_s st0, st1, st0_hi;

  // Next-state logic for configuration, prescaler, timers and readback
  always_comb begin
    mode0 = dtm_mode_e'(mode_sel_q[DTM_MODE_T0_LSB +: 2]);
    mode1 = dtm_mode_e'(mode_sel_q[DTM_MODE_T1_LSB +: 2]);
    scale = clk_sel_q[DTM_CLK_SCALE_LSB +: 2];
    wr_run = sfr_wr_en_in && (sfr_addr_in == DTM_ADDR_RUN_CTRL);
    wr_mode = sfr_wr_en_in && (sfr_addr_in == DTM_ADDR_MODE_SEL);
    wr_clk = sfr_wr_en_in && (sfr_addr_in == DTM_ADDR_CLK_SEL);

    // Prescaler runs from the system clock regardless of timer state
    case (scale)
      2'b00: div_last = DTM_DIV_12 - 6'h01;
      2'b01: div_last = DTM_DIV_4 - 6'h01;
      default: div_last = DTM_DIV_48 - 6'h01;
    endcase
    // Compare with >= so a ratio change never strands the counter
    pre_cnt_d = (pre_cnt_q >= div_last) ? 6'h00 : pre_cnt_q + 6'h01;

    // External clock: count settled rising edges, one tick per eight
    eclk_prev_d = eclk_lvl_q;
    ext_cnt_d = ext_cnt_q;
    if (eclk_lvl_q && !eclk_prev_q) begin
      ext_cnt_d = ext_cnt_q + 3'h1;
    end
    if (scale == 2'b11) begin
      pre_tick = eclk_lvl_q && !eclk_prev_q && (ext_cnt_q == DTM_EXT_DIV_LAST);
    end else begin
      pre_tick = (pre_cnt_q >= div_last);
    end

    // Per-timer clock source
    tick0 = clk_sel_q[DTM_CLK_T0_SYS_BIT] ? 1'b1 : pre_tick;
    tick1 = clk_sel_q[DTM_CLK_T1_SYS_BIT] ? 1'b1 : pre_tick;

    // Gating: external interrupt pins are active low
    run0 = t0_run_q && (!mode_sel_q[DTM_MODE_T0_GATE_BIT] || !irq0_lvl_q);
    run1 = t1_run_q && (!mode_sel_q[DTM_MODE_T1_GATE_BIT] || !irq1_lvl_q);
    hi0_run = (mode0 == DTM_MODE_SPLIT) && t1_run_q && tick0;

    // Timer 0 counting
    st0 = step_timer(t0_q, mode0);
    st0_hi = step_timer('{hi: 8'h00, lo: t0_q.hi}, DTM_MODE_SPLIT);
    t0_d = t0_q;
    set_flag0 = 1'b0;
    set_flag1 = 1'b0;
    if (run0 && tick0) begin
      t0_d.lo = st0.cnt.lo;
      if (mode0 != DTM_MODE_SPLIT) begin
        t0_d.hi = st0.cnt.hi;
      end
      set_flag0 = st0.ovf;
    end
    if (hi0_run) begin
      t0_d.hi = st0_hi.cnt.lo;
      set_flag1 = st0_hi.ovf;
    end

    // Timer 1 counting; inactive in its own mode 3
    st1 = step_timer(t1_q, mode1);
    t1_d = t1_q;
    t1_pulse_d = 1'b0;
    if (run1 && tick1 && (mode1 != DTM_MODE_SPLIT)) begin
      t1_d = st1.cnt;
      t1_pulse_d = st1.ovf;
      // With timer 0 split, timer 1 overflow only feeds the pulse
      if (mode0 != DTM_MODE_SPLIT) begin
        set_flag1 = st1.ovf;
      end
    end

    // Software writes to count bytes take priority over counting
    if (sfr_wr_en_in && (sfr_addr_in == DTM_ADDR_T0_LOW)) t0_d.lo = sfr_wr_data_in;
    if (sfr_wr_en_in && (sfr_addr_in == DTM_ADDR_T0_HIGH)) t0_d.hi = sfr_wr_data_in;
    if (sfr_wr_en_in && (sfr_addr_in == DTM_ADDR_T1_LOW)) t1_d.lo = sfr_wr_data_in;
    if (sfr_wr_en_in && (sfr_addr_in == DTM_ADDR_T1_HIGH)) t1_d.hi = sfr_wr_data_in;

    // Configuration; reserved and unused bits are never stored
    mode_sel_d = wr_mode ? (sfr_wr_data_in & DTM_MODE_WR_MASK) : mode_sel_q;
    clk_sel_d = wr_clk ? (sfr_wr_data_in & DTM_CLK_WR_MASK) : clk_sel_q;
    t0_run_d = wr_run ? sfr_wr_data_in[DTM_RUN_EN0_BIT] : t0_run_q;
    t1_run_d = wr_run ? sfr_wr_data_in[DTM_RUN_EN1_BIT] : t1_run_q;

    // Flags: a hardware set in the same cycle beats any clear
    // Writing one raises a flag, so software can post a timer request itself
    clr_flag0 = tmr0_vector_ack_in || (wr_run && !sfr_wr_data_in[DTM_RUN_FLAG0_BIT]);
    clr_flag1 = tmr1_vector_ack_in || (wr_run && !sfr_wr_data_in[DTM_RUN_FLAG1_BIT]);
    t0_flag_d = set_flag0 || (t0_flag_q && !clr_flag0) || (wr_run && sfr_wr_data_in[DTM_RUN_FLAG0_BIT]);
    t1_flag_d = set_flag1 || (t1_flag_q && !clr_flag1) || (wr_run && sfr_wr_data_in[DTM_RUN_FLAG1_BIT]);

    // Readback, one cycle after the read strobe; unmapped reads zero
    // Count bytes are not latched as a pair; a carry may land between reads
    rd_data_d = 8'h00;
    if (sfr_rd_en_in) begin
      case (sfr_addr_in)
        DTM_ADDR_RUN_CTRL: rd_data_d = {t1_flag_q, t1_run_q, t0_flag_q, t0_run_q, 4'h0} & DTM_RUN_WR_MASK;
        DTM_ADDR_MODE_SEL: rd_data_d = mode_sel_q;
        DTM_ADDR_CLK_SEL: rd_data_d = clk_sel_q;
        DTM_ADDR_T0_LOW: rd_data_d = t0_q.lo;
        DTM_ADDR_T0_HIGH: rd_data_d = t0_q.hi;
        DTM_ADDR_T1_LOW: rd_data_d = t1_q.lo;
        DTM_ADDR_T1_HIGH: rd_data_d = t1_q.hi;
        default: rd_data_d = 8'h00;
      endcase
    end
  end

  // State registers; every register clears on reset
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      mode_sel_q <= DTM_RESET_BYTE;
      clk_sel_q <= DTM_RESET_BYTE;
      t0_run_q <= 1'b0;
      t1_run_q <= 1'b0;
      t0_flag_q <= 1'b0;
      t1_flag_q <= 1'b0;
      t0_q <= '{hi: DTM_RESET_BYTE, lo: DTM_RESET_BYTE};
      t1_q <= '{hi: DTM_RESET_BYTE, lo: DTM_RESET_BYTE};
      pre_cnt_q <= 6'h00;
      ext_cnt_q <= 3'h0;
      eclk_prev_q <= 1'b0;
      rd_data_q <= 8'h00;
      t1_pulse_q <= 1'b0;
    end else begin
      mode_sel_q <= mode_sel_d;
      clk_sel_q <= clk_sel_d;
      t0_run_q <= t0_run_d;
      t1_run_q <= t1_run_d;
      t0_flag_q <= t0_flag_d;
      t1_flag_q <= t1_flag_d;
      t0_q <= t0_d;
      t1_q <= t1_d;
      pre_cnt_q <= pre_cnt_d;
      ext_cnt_q <= ext_cnt_d;
      eclk_prev_q <= eclk_prev_d;
      rd_data_q <= rd_data_d;
      t1_pulse_q <= t1_pulse_d;
    end
  end

  // Outputs straight from flip-flops
  assign sfr_rd_data_out = rd_data_q;
  assign timer0_overflow_flag_out = t0_flag_q;
  assign timer1_overflow_flag_out = t1_flag_q;
  assign timer1_ovf_pulse_out = t1_pulse_q;

endmodule

// File: inc/dtm_pkg.sv
// Package: register map, field positions and types for the dual timer block
package dtm_pkg;

  // Register offsets in the special-function register space
  localparam logic [7:0] DTM_ADDR_RUN_CTRL = 8'h88;
  localparam logic [7:0] DTM_ADDR_MODE_SEL = 8'h89;
  localparam logic [7:0] DTM_ADDR_T0_LOW = 8'h8A;
  localparam logic [7:0] DTM_ADDR_T1_LOW = 8'h8B;
  localparam logic [7:0] DTM_ADDR_T0_HIGH = 8'h8C;
  localparam logic [7:0] DTM_ADDR_T1_HIGH = 8'h8D;
  localparam logic [7:0] DTM_ADDR_CLK_SEL = 8'h8E;

  // Mode register fields
  localparam int DTM_MODE_T1_GATE_BIT = 7;
  localparam int DTM_MODE_T1_LSB = 4;
  localparam int DTM_MODE_T0_GATE_BIT = 3;
  localparam int DTM_MODE_T0_LSB = 0;
  localparam logic [7:0] DTM_MODE_WR_MASK = 8'hBB;

  // Clock select register fields
  localparam int DTM_CLK_T1_SYS_BIT = 3;
  localparam int DTM_CLK_T0_SYS_BIT = 2;
  localparam int DTM_CLK_SCALE_LSB = 0;
  localparam logic [7:0] DTM_CLK_WR_MASK = 8'h0F;

  // Run control register fields
  localparam int DTM_RUN_FLAG1_BIT = 7;
  localparam int DTM_RUN_EN1_BIT = 6;
  localparam int DTM_RUN_FLAG0_BIT = 5;
  localparam int DTM_RUN_EN0_BIT = 4;
  localparam logic [7:0] DTM_RUN_WR_MASK = 8'hF0;

  // Reset values
  localparam logic [7:0] DTM_RESET_BYTE = 8'h00;

  // Prescaler divide ratios
  localparam logic [5:0] DTM_DIV_12 = 6'h0C;
  localparam logic [5:0] DTM_DIV_4 = 6'h04;
  localparam logic [5:0] DTM_DIV_48 = 6'h30;
  localparam logic [2:0] DTM_EXT_DIV_LAST = 3'h7;

  // Timer operating modes
  typedef enum logic [1:0] {
    DTM_MODE_13BIT = 2'b00,
    DTM_MODE_16BIT = 2'b01,
    DTM_MODE_RELOAD8 = 2'b10,
    DTM_MODE_SPLIT = 2'b11
  } dtm_mode_e;

  // One timer's count, high and low byte
  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } dtm_count_s;

  // Result of one count step
  typedef struct packed {
    dtm_count_s cnt;
    logic ovf;
  } dtm_step_s;

endpackage

// File: verif/dtm_timer_monitor.sv
// Checker for readback and overflow flags of the dual timer
module dtm_timer_monitor (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Register access
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_en_in,
  input wire logic [7:0] sfr_wr_data_in,
  input wire logic sfr_rd_en_in,
  input wire logic [7:0] sfr_rd_data_out,
  // Acknowledges and flags
  input wire logic tmr0_vector_ack_in,
  input wire logic tmr1_vector_ack_in,
  input wire logic timer0_overflow_flag_out,
  input wire logic timer1_overflow_flag_out,
  input wire logic timer1_ovf_pulse_out
);
  logic run_wr;
  logic split_q;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  // Writes to the run and flag register
  assign run_wr = sfr_wr_en_in && sfr_addr_in == 8'h88;
  // Shadow of timer 0 split mode; then its high byte, not timer 1, raises flag 1
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      split_q <= 1'b0;
    end else if (sfr_wr_en_in && sfr_addr_in == 8'h89) begin
      split_q <= (sfr_wr_data_in[1:0] == 2'b11);
    end
  end
  ////////////////////////////////////////
  // Read data answers a strobe only
  rd_idle_a: assert property (!sfr_rd_en_in |=> sfr_rd_data_out == 8'h00)
    else $error("read data not idle");
  // Bits that do not store read zero
  mode_rsvd_a: assert property (sfr_rd_en_in && sfr_addr_in == 8'h89
    |=> (sfr_rd_data_out & 8'h44) == 8'h00) else $error("mode reserved bits");
  clk_upper_a: assert property (sfr_rd_en_in && sfr_addr_in == 8'h8E
    |=> (sfr_rd_data_out & 8'hF0) == 8'h00) else $error("clock upper bits");
  // Flags fall only on an acknowledge or a write
  flag0_hold_a: assert property ($fell(timer0_overflow_flag_out)
    |-> $past(tmr0_vector_ack_in) || $past(run_wr)) else $error("flag 0 lost");
  flag1_hold_a: assert property ($fell(timer1_overflow_flag_out)
    |-> $past(tmr1_vector_ack_in) || $past(run_wr)) else $error("flag 1 lost");
  // Hardware sets flag 1 only with an overflow
  flag1_src_a: assert property ($rose(timer1_overflow_flag_out) && !$past(run_wr) && !$past(split_q)
    |-> timer1_ovf_pulse_out) else $error("flag 1 without overflow");
  // Writing one sets a flag
  flag0_set_a: assert property (run_wr && sfr_wr_data_in[5] |=> timer0_overflow_flag_out)
    else $error("flag 0 not set");
  flag1_set_a: assert property (run_wr && sfr_wr_data_in[7] |=> timer1_overflow_flag_out)
    else $error("flag 1 not set");
  // Main scenarios reached
  cover property (timer1_ovf_pulse_out && timer1_overflow_flag_out);
  cover property (tmr0_vector_ack_in && timer0_overflow_flag_out);
  cover property (sfr_rd_en_in && sfr_addr_in == 8'h8E);
  cover property ($rose(timer1_overflow_flag_out) && $past(split_q));
endmodule

bind dtm_timer_top dtm_timer_monitor mon_u (.clk_in, .rst_b_in, .sfr_addr_in, .sfr_wr_en_in,
  .sfr_wr_data_in, .sfr_rd_en_in, .sfr_rd_data_out, .tmr0_vector_ack_in, .tmr1_vector_ack_in,
  .timer0_overflow_flag_out, .timer1_overflow_flag_out, .timer1_ovf_pulse_out);

// File: verif/dtm_timer_top_tb.sv
// Self-checking bench for the dual timer block
module dtm_timer_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = '0, rst_b_in = '0, wr = '0, rd = '0, eclk = '0, ack0 = '0, ack1 = '0;
  logic irq0_n = '1, irq1_n = '1, f0, f1, pls;
  logic [7:0] addr = '0, wdat = '0, rdat, v, a0, a1, b0, b1;
  int errors = 0, compares = 0, cyc = 0, seed = 96157;
  int divs[$] = '{12, 4, 48, 64};
  // Device under test
  dtm_timer_top dut_u (.clk_in, .rst_b_in, .sfr_addr_in(addr), .sfr_wr_en_in(wr), .sfr_wr_data_in(wdat),
    .sfr_rd_en_in(rd), .sfr_rd_data_out(rdat), .ext_irq0_n_in(irq0_n), .ext_irq1_n_in(irq1_n),
    .ext_clk_in(eclk), .tmr0_vector_ack_in(ack0), .tmr1_vector_ack_in(ack1),
    .timer0_overflow_flag_out(f0), .timer1_overflow_flag_out(f1), .timer1_ovf_pulse_out(pls));
  always #25 clk_in = ~clk_in;
  // External clock at one eighth rate, and a ceiling on run length
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3) eclk <= ~eclk;
    if (cyc == 5000) begin
      errors++;
      wrap_up();
    end
  end
  ////////////////////////////////////////
  // Model: ticks in a window of w cycles
  function automatic logic [7:0] ticks(input int w, input int d, input bit on);
    return on ? 8'(w / d) : 8'h00;
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 d = rdat;
  endtask
  // Both low bytes sampled w cycles apart
  task automatic span(input int w);
    rreg(8'h8A, a0);
    rreg(8'h8B, a1);
    repeat (w - 4) @(posedge clk_in);
    rreg(8'h8A, b0);
    rreg(8'h8B, b1);
  endtask
  task automatic wrap_up();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_in);
    rst_b_in <= 1'b1;
    // Reset values, unmapped places last
    for (int i = 136; i < 145; i++) begin
      rreg(8'(i), v);
      check(v, 8'h00);
    end
    // Random values, timers stopped
    for (int i = 0; i < 8; i++) begin
      v = 8'($random(seed));
      wreg(8'h89, v);
      rreg(8'h89, a0);
      check(a0, v & 8'hBB);
      wreg(8'h8E, v);
      rreg(8'h8E, a0);
      check(a0, v & 8'h0F);
      wreg(8'h8A + 8'(i % 4), v);
      rreg(8'h8A + 8'(i % 4), a0);
      check(a0, v);
    end
    $display("registers done");
    // Timer 0 on each prescale code, timer 1 on system clock
    wreg(8'h89, 8'h11);
    wreg(8'h88, 8'h50);
    for (int s = 0; s < 4; s++) begin
      wreg(8'h8E, 8'h08 + 8'(s));
      repeat (150) @(posedge clk_in);
      span(2 * divs[s]);
      check(b0 - a0, ticks(2 * divs[s], divs[s], 1'b1));
      check(b1 - a1, ticks(2 * divs[s], 1, 1'b1));
    end
    wreg(8'h8E, 8'h05);
    repeat (20) @(posedge clk_in);
    span(16);
    check(b1 - a1, ticks(16, 4, 1'b1));
    $display("prescale done");
    // Gate bits against pin levels
    wreg(8'h8E, 8'h0C);
    for (int g = 0; g < 8; g++) begin
      wreg(8'h89, g[2] ? 8'h99 : 8'h11);
      irq0_n <= g[0];
      irq1_n <= g[1];
      repeat (8) @(posedge clk_in);
      span(16);
      check(b0 - a0, ticks(16, 1, !(g[2] && g[0])));
      check(b1 - a1, ticks(16, 1, !(g[2] && g[1])));
    end
    $display("gate done");
    // Wrap of 13-bit timer 0, reload of timer 1
    wreg(8'h88, 8'h00);
    wreg(8'h89, 8'h20);
    wreg(8'h8C, 8'hFF);
    wreg(8'h8A, 8'h1D);
    wreg(8'h8D, 8'hA0);
    wreg(8'h8B, 8'hFD);
    wreg(8'h88, 8'h50);
    repeat (12) @(posedge clk_in);
    #1 check(8'({f1, f0}), 8'h03);
    wreg(8'h88, 8'hA0);
    rreg(8'h8C, v);
    check(v, 8'h00);
    rreg(8'h8D, v);
    check(v, 8'hA0);
    rreg(8'h8B, v);
    check(v & 8'hF0, 8'hA0);
    // Acknowledge, then software set and clear
    @(posedge clk_in);
    ack0 <= 1'b1;
    ack1 <= 1'b1;
    @(posedge clk_in);
    ack0 <= 1'b0;
    ack1 <= 1'b0;
    #1 check(8'({f1, f0}), 8'h00);
    wreg(8'h88, 8'hA0);
    #1 check(8'({f1, f0}), 8'h03);
    wreg(8'h88, 8'h00);
    #1 check(8'({f1, f0}), 8'h00);
    // Reload on timer 0, 13-bit wrap and pulse on timer 1
    wreg(8'h89, 8'h02);
    wreg(8'h8C, 8'hB0);
    wreg(8'h8A, 8'hFE);
    wreg(8'h8D, 8'hFF);
    wreg(8'h8B, 8'h1E);
    wreg(8'h88, 8'h50);
    repeat (2) @(posedge clk_in);
    #1 check(8'(pls), 8'h01);
    repeat (10) @(posedge clk_in);
    #1 check(8'({f1, f0, pls}), 8'h06);
    wreg(8'h88, 8'h00);
    rreg(8'h8A, v);
    check(v & 8'hF0, 8'hB0);
    rreg(8'h8D, v);
    check(v, 8'h00);
    $display("overflow done");
    // Split: high byte runs on timer 1 run bit
    wreg(8'h89, 8'h33);
    wreg(8'h8C, 8'hFC);
    wreg(8'h8A, 8'h55);
    wreg(8'h8B, 8'h66);
    wreg(8'h88, 8'h40);
    repeat (12) @(posedge clk_in);
    #1 check(8'({f1, f0}), 8'h02);
    wreg(8'h88, 8'h80);
    rreg(8'h8A, v);
    check(v, 8'h55);
    rreg(8'h8B, v);
    check(v, 8'h66);
    $display("split done");
    wrap_up();
  end
endmodule
